//--- include/fine_gain_defs.vh
// offsets, field positions, reset values and fuse bit positions for the fine gain trim bank
`ifndef FINE_GAIN_DEFS_VH
`define FINE_GAIN_DEFS_VH
`define ADDR_W 12
`define OFS_GAIN_C2_A 12'h362
`define OFS_GAIN_C2_B 12'h363
`define OFS_GAIN_C3_C 12'h364
`define OFS_GAIN_C3_D 12'h365
`define OFS_GAIN_C4 12'h366
`define OFS_GAIN_C5 12'h367
`define TRIM_MSB 4
`define TRIM_W 5
`define RSVD_MSB 7
`define RSVD_LSB 5
`define GAIN_RESET 5'h00
`define NUM_TRIMS 6
`define FUSE_C2A_LSB 0
`define FUSE_C2B_LSB 5
`define FUSE_C3C_LSB 10
`define FUSE_C3D_LSB 15
`define FUSE_C4_LSB 20
`define FUSE_C5_LSB 25
`endif

//--- verilog/converter_fine_gain_trim.v
// fine gain trim register bank with fuse load and per-input trim selection
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`include "fine_gain_defs.vh"

// What this block does
// - core 2 uses trim at 0x363 bits 4:0 only while sampling input b
// - core 3 uses trim at 0x364 only while sampling input c
// - core 3 uses trim at 0x365 only while sampling input d
// - core 4 uses trim at 0x366 whatever input is selected
// - core 5 uses trim at 0x367 whatever input is selected
// - after power-up each trim field is loaded from fuse memory
// - register 0x362 gives core 2 trim while sampling input a
module converter_fine_gain_trim (
  input wire core_clk, // 200 MHz configuration clock
  input wire rst_n, // asynchronous reset, active low
  input wire [11:0] reg_addr, // register byte address
  input wire [7:0] reg_wdata, // write data
  input wire reg_wr, // write strobe, one cycle
  input wire reg_rd, // read strobe, one cycle
  output reg [7:0] reg_rdata, // read data, valid the cycle after reg_rd
  input wire fuse_valid, // fuse values ready, one-cycle pulse or level
  input wire [29:0] fuse_trims, // fuse codes c2a,c2b,c3c,c3d,c4,c5 from low bits
  input wire core2_sel_b, // core 2 samples input b (else input a)
  input wire core3_sel_d, // core 3 samples input d (else input c)
  output reg [4:0] core2_trim, // trim applied to core 2
  output reg [4:0] core3_trim, // trim applied to core 3
  output reg [4:0] core4_trim, // trim applied to core 4
  output reg [4:0] core5_trim, // trim applied to core 5
  output reg fuse_loaded // fuse defaults have been taken
);

  // fuse load sequencing, one-hot
  localparam [1:0] LD_WAIT = 2'b01;
  localparam [1:0] LD_DONE = 2'b10;

  // register select codes from the address decoder
  localparam [2:0] SEL_C2A = 3'h0;
  localparam [2:0] SEL_C2B = 3'h1;
  localparam [2:0] SEL_C3C = 3'h2;
  localparam [2:0] SEL_C3D = 3'h3;
  localparam [2:0] SEL_C4 = 3'h4;
  localparam [2:0] SEL_C5 = 3'h5;
  localparam [2:0] SEL_NONE = 3'h6;

  reg [1:0] load_state_ff;
  reg [1:0] nxt_load_state;
  reg fuse_take;
  reg [4:0] trim_c2a_ff;
  reg [4:0] trim_c2b_ff;
  reg [4:0] trim_c3c_ff;
  reg [4:0] trim_c3d_ff;
  reg [4:0] trim_c4_ff;
  reg [4:0] trim_c5_ff;
  reg [7:0] nxt_rdata;
  wire [2:0] wr_sel;
  wire [2:0] rd_sel;
  wire wr_c2a;
  wire wr_c2b;
  wire wr_c3c;
  wire wr_c3d;
  wire wr_c4;
  wire wr_c5;

  // select code of a trim register, none when unmapped
  function [2:0] trim_index;
    input [11:0] addr;
    begin
      case (addr)
        `OFS_GAIN_C2_A: trim_index = SEL_C2A;
        `OFS_GAIN_C2_B: trim_index = SEL_C2B;
        `OFS_GAIN_C3_C: trim_index = SEL_C3C;
        `OFS_GAIN_C3_D: trim_index = SEL_C3D;
        `OFS_GAIN_C4: trim_index = SEL_C4;
        `OFS_GAIN_C5: trim_index = SEL_C5;
        default: trim_index = SEL_NONE;
      endcase
    end
  endfunction

  // trim of the input a core is sampling
  function [4:0] pick_trim;
    input sel_second;
    input [4:0] first_trim;
    input [4:0] second_trim;
    begin
      if (sel_second)
        pick_trim = second_trim;
      else
        pick_trim = first_trim;
    end
  endfunction

  // a write that hits one register; lost while fuses are taken
  function write_hit;
    input [2:0] sel;
    input [2:0] code;
    input wr;
    input taking;
    begin
      write_hit = wr && !taking && (sel == code);
    end
  endfunction

  assign wr_sel = trim_index(reg_addr);
  assign rd_sel = trim_index(reg_addr);
  assign wr_c2a = write_hit(wr_sel, SEL_C2A, reg_wr, fuse_take);
  assign wr_c2b = write_hit(wr_sel, SEL_C2B, reg_wr, fuse_take);
  assign wr_c3c = write_hit(wr_sel, SEL_C3C, reg_wr, fuse_take);
  assign wr_c3d = write_hit(wr_sel, SEL_C3D, reg_wr, fuse_take);
  assign wr_c4 = write_hit(wr_sel, SEL_C4, reg_wr, fuse_take);
  assign wr_c5 = write_hit(wr_sel, SEL_C5, reg_wr, fuse_take);

  // fuse load once
  // fuses are taken only on the first valid after reset, never again
  always @* begin
    nxt_load_state = load_state_ff;
    fuse_take = 1'b0;
    case (load_state_ff)
      LD_WAIT: begin
        if (fuse_valid) begin
          fuse_take = 1'b1;
          nxt_load_state = LD_DONE;
        end
      end
      LD_DONE: begin
        nxt_load_state = LD_DONE;
      end
      default: begin
        nxt_load_state = LD_WAIT;
      end
    endcase
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      load_state_ff <= LD_WAIT;
    end else begin
      load_state_ff <= nxt_load_state;
    end
  end

  // core 2 input a store
  // reserved bits are not stored, so they always read back zero
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      trim_c2a_ff <= `GAIN_RESET;
    end else if (fuse_take) begin
      trim_c2a_ff <= fuse_trims[`FUSE_C2A_LSB +: `TRIM_W];
    end else if (wr_c2a) begin
      trim_c2a_ff <= reg_wdata[`TRIM_MSB:0];
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      trim_c2b_ff <= `GAIN_RESET;
    end else if (fuse_take) begin
      trim_c2b_ff <= fuse_trims[`FUSE_C2B_LSB +: `TRIM_W];
    end else if (wr_c2b) begin
      trim_c2b_ff <= reg_wdata[`TRIM_MSB:0];
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      trim_c3c_ff <= `GAIN_RESET;
    end else if (fuse_take) begin
      trim_c3c_ff <= fuse_trims[`FUSE_C3C_LSB +: `TRIM_W];
    end else if (wr_c3c) begin
      trim_c3c_ff <= reg_wdata[`TRIM_MSB:0];
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      trim_c3d_ff <= `GAIN_RESET;
    end else if (fuse_take) begin
      trim_c3d_ff <= fuse_trims[`FUSE_C3D_LSB +: `TRIM_W];
    end else if (wr_c3d) begin
      trim_c3d_ff <= reg_wdata[`TRIM_MSB:0];
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      trim_c4_ff <= `GAIN_RESET;
    end else if (fuse_take) begin
      trim_c4_ff <= fuse_trims[`FUSE_C4_LSB +: `TRIM_W];
    end else if (wr_c4) begin
      trim_c4_ff <= reg_wdata[`TRIM_MSB:0];
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      trim_c5_ff <= `GAIN_RESET;
    end else if (fuse_take) begin
      trim_c5_ff <= fuse_trims[`FUSE_C5_LSB +: `TRIM_W];
    end else if (wr_c5) begin
      trim_c5_ff <= reg_wdata[`TRIM_MSB:0];
    end
  end

  always @* begin
    nxt_rdata = 8'h00;
    if (reg_rd) begin
      case (rd_sel)
        SEL_C2A: nxt_rdata = {3'h0, trim_c2a_ff};
        SEL_C2B: nxt_rdata = {3'h0, trim_c2b_ff};
        SEL_C3C: nxt_rdata = {3'h0, trim_c3c_ff};
        SEL_C3D: nxt_rdata = {3'h0, trim_c3d_ff};
        SEL_C4: nxt_rdata = {3'h0, trim_c4_ff};
        SEL_C5: nxt_rdata = {3'h0, trim_c5_ff};
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  // trims registered so a select change never glitches the core
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
      core2_trim <= `GAIN_RESET;
      core3_trim <= `GAIN_RESET;
      core4_trim <= `GAIN_RESET;
      core5_trim <= `GAIN_RESET;
      fuse_loaded <= 1'b0;
    end else begin
      reg_rdata <= nxt_rdata;
      core2_trim <= pick_trim(core2_sel_b, trim_c2a_ff, trim_c2b_ff);
      core3_trim <= pick_trim(core3_sel_d, trim_c3c_ff, trim_c3d_ff);
      core4_trim <= trim_c4_ff;
      core5_trim <= trim_c5_ff;
      fuse_loaded <= (load_state_ff == LD_DONE);
    end
  end

endmodule // converter_fine_gain_trim

//--- bench/fine_gain_checker.sv
// fine gain trim bank checker
`timescale 1ns/1ps
module fine_gain_checker(input wire core_clk,rst_n,reg_wr,reg_rd,fuse_valid,core2_sel_b,
  core3_sel_d,fuse_loaded,input wire [11:0] reg_addr,input wire [7:0] reg_wdata,reg_rdata,
  input wire [29:0] fuse_trims,input wire [4:0] core2_trim,core3_trim,core4_trim,core5_trim);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_wr_settle(a,sel);
    fuse_loaded&&reg_wr&&reg_addr==a&&sel ##1 !reg_wr&&sel;
  endsequence
  property p_t(a,s,t);
    s_wr_settle(a,s) |-> ##1 t==$past(reg_wdata[4:0],2);
  endproperty
  a_core2_in_a: assert property (p_t(12'h362,!core2_sel_b,core2_trim)) else $error("c2a");
  a_core2_in_b: assert property (p_t(12'h363,core2_sel_b,core2_trim)) else $error("c2b");
  a_core3_in_c: assert property (p_t(12'h364,!core3_sel_d,core3_trim)) else $error("c3c");
  a_core3_in_d: assert property (p_t(12'h365,core3_sel_d,core3_trim)) else $error("c3d");
  a_core4_any: assert property (p_t(12'h366,1'b1,core4_trim)) else $error("c4");
  a_core5_any: assert property (p_t(12'h367,1'b1,core5_trim)) else $error("c5");
  a_fuse_load: assert property ($rose(fuse_loaded) |-> core5_trim==$past(fuse_trims[29:25],2))
    else $error("fuse");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata==8'h00) else $error("idle");
  a_rdata_unmapped: assert property (reg_rd&&reg_addr==12'h368 |=> reg_rdata==8'h00)
    else $error("unmapped");
  a_rdata_rsvd: assert property (reg_rd |=> reg_rdata[7:5]==3'h0) else $error("rsvd");
endmodule // fine_gain_checker
bind converter_fine_gain_trim fine_gain_checker fine_gain_checker_i(.*);

//--- bench/tb_top.sv
// self-checking bench for the fine gain trim bank
`timescale 1ns/1ps
module tb_top;
  reg core_clk=0,rst_n=0,reg_wr=0,reg_rd=0,fuse_valid=1,core2_sel_b=0,core3_sel_d=0;
  reg [11:0] reg_addr=0;
  reg [7:0] reg_wdata=0;
  reg [29:0] fuse_trims=0,ex;
  reg [31:0] s;
  wire [7:0] reg_rdata;
  wire [4:0] core2_trim,core3_trim,core4_trim,core5_trim;
  wire fuse_loaded;
  integer num_errors=0,total_checks=0,i,j;
  converter_fine_gain_trim converter_fine_gain_trim_i(.core_clk(core_clk),.rst_n(rst_n),
    .reg_addr(reg_addr),.reg_wdata(reg_wdata),.reg_wr(reg_wr),.reg_rd(reg_rd),
    .reg_rdata(reg_rdata),.fuse_valid(fuse_valid),.fuse_trims(fuse_trims),
    .core2_sel_b(core2_sel_b),.core3_sel_d(core3_sel_d),.core2_trim(core2_trim),
    .core3_trim(core3_trim),.core4_trim(core4_trim),.core5_trim(core5_trim),
    .fuse_loaded(fuse_loaded));
  function [7:0] exp_rd(input integer k); exp_rd={3'h0,ex[k*5+:5]}; endfunction
  initial forever #2.5 core_clk=~core_clk;
  task chk(input [7:0] g,e); begin
    total_checks=total_checks+1;
    if (g!==e) begin num_errors=num_errors+1; $display("ERROR %0t %h %h",$time,g,e); end
  end endtask
  task op(input w,r,input [11:0] a,input [7:0] d); begin
    @(posedge core_clk); reg_wr<=w; reg_rd<=r; reg_addr<=a; reg_wdata<=d;
  end endtask
  task rd(input [11:0] a,input [7:0] e); begin
    op(0,1,a,0); op(0,0,0,0); #1 chk(reg_rdata,e);
  end endtask
  task report_and_stop; begin
    $display("checks %0d errors %0d",total_checks,num_errors);
    if (num_errors==0 && total_checks>0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  end endtask
  initial begin
    s=$urandom(32'h6262);
    s=$urandom; fuse_trims=s[29:0]; ex=s[29:0];
    repeat (4) @(posedge core_clk);
    rst_n<=1;
    for (i=0;i<6;i=i+1) rd(12'h362+i[11:0],exp_rd(i));
    chk({7'h0,fuse_loaded},8'h01);
    $display("fuse test done");
    // select input a/c, then b/d
    for (j=0;j<2;j=j+1) begin
      @(posedge core_clk); core2_sel_b<=j[0]; core3_sel_d<=j[0];
      for (i=0;i<6;i=i+1) begin
        s=$urandom; ex[i*5+:5]=s[4:0]; op(1,0,12'h362+i[11:0],{3'h0,s[4:0]}); op(0,0,0,0);
      end
      op(0,0,0,0); #1;
      chk({3'h0,core2_trim},{3'h0,ex[j*5+:5]});
      chk({3'h0,core3_trim},{3'h0,ex[10+j*5+:5]});
      chk({3'h0,core4_trim},{3'h0,ex[24:20]});
      chk({3'h0,core5_trim},{3'h0,ex[29:25]});
      for (i=0;i<6;i=i+1) rd(12'h362+i[11:0],exp_rd(i));
      $display("select test done");
    end
    // select back to input a/c with no write
    @(posedge core_clk); core2_sel_b<=0; core3_sel_d<=0;
    op(0,0,0,0); op(0,0,0,0); #1;
    chk({3'h0,core2_trim},exp_rd(0));
    chk({3'h0,core3_trim},exp_rd(2));
    $display("reselect test done");
    // unmapped place keeps nothing
    op(1,0,12'h368,8'h15); rd(12'h368,8'h00);
    report_and_stop;
  end
endmodule // tb_top
